/* sim/tic_checker_properties.sv */
/* Port assertions for the transceive and flag control block.
   Assumes one clock and an active-low reset; attached by the bind below. */
module tic_checker #(
    parameter int BUF_ADDR_W = 9
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [6:0] reg_idx,
    input wire logic [31:0] reg_rdata,
    input wire logic [19:0] flag_event,
    input wire logic cmd_transceive,
    input wire logic cmd_stop,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_frame_end,
    input wire logic irq,
    input wire logic [2:0] fsm_state,
    input wire logic rx_enable,
    input wire logic buf_we,
    input wire logic [BUF_ADDR_W-1:0] buf_addr,
    input wire logic [7:0] buf_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // All checks share the block clock and its reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Copy of the auto-rearm bit, taken from writes to the control register.
    logic rearm_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rearm_reg <= 1'b0;
        end else if (reg_wr && reg_idx == 7'h04) begin
            rearm_reg <= reg_wdata[1];
        end
    end
    // A byte taken while receiving, and the end of a frame while receiving.
    sequence s_rx_byte;
        fsm_state == 3'h7 && rx_byte_valid && !cmd_stop;
    endsequence
    sequence s_frame_end;
        fsm_state == 3'h7 && rx_frame_end && !cmd_stop;
    endsequence
    a_clear_reads_zero: assert property (reg_rd && reg_idx == 7'h03 |=> reg_rdata == 32'h0)
        else $error("flag clear register kept a value");
    a_fixed_flag_irq: assert property (flag_event[19] |-> ##2 irq)
        else $error("always enabled flag did not raise irq");
    a_stop_goes_idle: assert property (cmd_stop |=> fsm_state == 3'h0)
        else $error("stop did not return to idle");
    a_idle_waits_cmd: assert property (fsm_state == 3'h0 && !cmd_transceive |=> fsm_state == 3'h0)
        else $error("left idle without a command");
    a_rx_enable_match: assert property (rx_enable == (fsm_state == 3'h6 || fsm_state == 3'h7))
        else $error("receiver enable disagrees with state");
    a_byte_stored: assert property (s_rx_byte |=> buf_we && buf_wdata == $past(rx_byte))
        else $error("received byte not written");
    a_frame_closes: assert property (s_frame_end ##0 rearm_reg |=> fsm_state == 3'h5)
        else $error("frame end did not close the frame");
    a_pad_is_zero: assert property (buf_we && $past(buf_we) && $past(fsm_state) == 3'h5 && $past(fsm_state, 2) == 3'h5
        && buf_addr[1:0] != 2'h0 |->
        buf_wdata == 8'h00)
        else $error("padding byte not zero");
endmodule

bind tic_transceive_irq_control tic_checker #(.BUF_ADDR_W(BUF_ADDR_W)) chk (.clk, .resetn, .reg_wr, .reg_wdata,
    .reg_rd, .reg_idx,
    .reg_rdata, .flag_event, .cmd_transceive, .cmd_stop, .rx_byte_valid, .rx_byte, .rx_frame_end, .irq, .fsm_state,
    .rx_enable, .buf_we, .buf_addr, .buf_wdata);

/* sim/tic_radio_model.sv */
/* Radio receive side model: plays one two-byte frame for each go pulse.
   Assumes the block samples these inputs on the rising clock edge. */
module tic_radio_model (
    input wire logic clk,
    input wire logic go,
    output logic rx_frame_start,
    output logic rx_byte_valid,
    output logic [7:0] rx_byte,
    output logic rx_frame_end,
    output logic [7:0] rx_frame_status
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] step_reg = 3'h0;
    // Steps 1 to 4 are frame start, two bytes and frame end, then the model rests.
    always @(posedge clk) begin
        step_reg <= (go || step_reg != 3'h0) && step_reg != 3'h5 ? step_reg + 3'h1 : 3'h0;
    end
    // Idle data lines show the inverse of their last value, so a stale byte is never mistaken for data.
    assign rx_frame_start = step_reg == 3'h1;
    assign rx_byte_valid = step_reg == 3'h2 || step_reg == 3'h3;
    assign rx_byte = step_reg == 3'h2 ? 8'hA5 : 8'hC3 ^ {8{step_reg == 3'h3}};
    assign rx_frame_end = step_reg == 3'h4;
    // The block takes the status one cycle after the frame end, so it stands for two cycles.
    assign rx_frame_status = step_reg == 3'h4 || step_reg == 3'h5 ? 8'h81 : 8'h7E;
endmodule

/* sim/tic_transceive_irq_control_tb.sv */
/* Self-checking bench for the transceive and flag control block.
   Needs the radio model and the checker; drives inputs on falling edges. */
module tic_transceive_irq_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, radio_go = 1'b0, go_seen = 1'b0;
    logic cmd_transceive = 1'b0, cmd_stop = 1'b0, send_trigger = 1'b0, guard_expired = 1'b0;
    logic tx_byte_done = 1'b0, listen_wait_done = 1'b0;
    logic [6:0] reg_idx = 7'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
    logic [19:0] flag_event = 20'h0;
    logic irq, tx_frame_go, tx_paused, tx_single_byte, rx_enable, buf_we, rx_frame_start, rx_byte_valid, rx_frame_end;
    logic [2:0] fsm_state;
    logic [8:0] buf_addr;
    logic [7:0] buf_wdata, rx_byte, rx_frame_status;
    logic [7:0] mem [0:7];
    int mismatches = 0, tests_run = 0;
    // Rows: flag events, clear value, expected status afterwards.
    logic [59:0] rows [8] = '{60'hFFFFF_E0000_1FFFF, 60'h00000_1C000_03FFF, 60'h00000_03800_007FF,
        60'h00000_007C0_0003F, 60'h00000_0003F_00000, 60'hAAAAA_00000_AAAAA, 60'h00000_55555_AAAAA,
        60'h00000_AAAAA_00000};
    tic_transceive_irq_control #(.BUF_ADDR_W(9)) uut (.clk, .resetn, .reg_wr, .reg_rd, .reg_idx, .reg_wdata,
        .reg_rdata, .flag_event, .cmd_transceive, .cmd_stop, .send_trigger, .guard_expired, .tx_byte_done,
        .tx_last_byte(1'b0), .listen_wait_done, .rx_frame_start, .rx_byte_valid, .rx_byte, .rx_frame_end,
        .rx_frame_status, .irq, .fsm_state, .tx_frame_go, .tx_paused, .tx_single_byte, .rx_enable, .buf_we,
        .buf_addr, .buf_wdata);
    tic_radio_model radio (.clk, .go(radio_go), .rx_frame_start, .rx_byte_valid, .rx_byte, .rx_frame_end,
        .rx_frame_status);
    // The clock toggles every half period of 10 ns.
    always #10 clk = ~clk;
    // Buffer writes to addresses 0 to 7 are recorded and any transmit frame start is remembered.
    always @(posedge clk) begin
        if (buf_we && buf_addr < 9'h008) begin
            mem[buf_addr[2:0]] <= buf_wdata;
        end
        if (tx_frame_go) begin
            go_seen <= 1'b1;
        end
    end
    // Compares a seen value against its expectation and counts both.
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Register accesses take one strobe cycle and one idle cycle.
    task wr(input logic [6:0] idx, input logic [31:0] d);
        {reg_wr, reg_idx, reg_wdata} = {1'b1, idx, d};
        @(negedge clk);
        reg_wr = 1'b0;
        @(negedge clk);
    endtask
    task rd(input logic [6:0] idx, output logic [31:0] d);
        {reg_rd, reg_idx} = {1'b1, idx};
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    // Pulses command and timing inputs for one cycle, then rests a cycle.
    task kick(input logic [5:0] m);
        {cmd_transceive, cmd_stop, send_trigger, guard_expired, tx_byte_done, listen_wait_done} = m;
        @(negedge clk);
        {cmd_transceive, cmd_stop, send_trigger, guard_expired, tx_byte_done, listen_wait_done} = 6'h00;
        @(negedge clk);
    endtask
    // Waits a bounded time for a state; running out ends the run.
    task wait_state(input logic [2:0] s);
        int n;
        n = 0;
        while (fsm_state !== s && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (n == 40) begin
            mismatches++;
            $display("wrong value at %0t: state %0d never reached", $time, s);
            end_of_test();
        end
    endtask
    task end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Main sequence: reset, table of flag cases, then the transceive cases.
    initial begin
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        rd(tic_pkg::TRANSCEIVE_CONTROL_IDX, v);
        check(v, 32'h0);
        rd(tic_pkg::IRQ_ENABLE_IDX, v);
        check(v, 32'hE0000);
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            flag_event = rows[i][59:40];
            @(negedge clk);
            flag_event = 20'h0;
            wr(tic_pkg::INTERRUPT_FLAG_CLEAR_IDX, {12'h0, rows[i][39:20]});
            rd(tic_pkg::IRQ_STATUS_IDX, v);
            check(v, {12'h0, rows[i][19:0]});
        end
        {flag_event, reg_wr, reg_idx, reg_wdata} = {20'h00008, 1'b1, tic_pkg::INTERRUPT_FLAG_CLEAR_IDX, 32'h8};
        @(negedge clk);
        {flag_event, reg_wr} = {20'h0, 1'b0};
        @(negedge clk);
        wr(7'h10, 32'hFFFFFFFF);
        rd(tic_pkg::IRQ_STATUS_IDX, v);
        check(v, 32'h8);
        rd(tic_pkg::INTERRUPT_FLAG_CLEAR_IDX, v);
        check(v, 32'h0);
        wr(tic_pkg::INTERRUPT_FLAG_CLEAR_IDX, 32'h8);
        $display("flag table done");
        wr(tic_pkg::TRANSCEIVE_CONTROL_IDX, 32'h023);
        kick(6'h20);
        check(fsm_state, tic_pkg::TIC_PRE_SEND_WAIT);
        check(irq, 1'b0);
        wr(tic_pkg::IRQ_ENABLE_IDX, 32'h20);
        check(irq, 1'b1);
        wr(tic_pkg::INTERRUPT_FLAG_CLEAR_IDX, 32'h20);
        check(irq, 1'b0);
        wr(tic_pkg::TRANSCEIVE_CONTROL_IDX, 32'h08B);
        go_seen = 1'b0;
        kick(6'h0C);
        wait_state(tic_pkg::TIC_PRE_LISTEN_WAIT);
        check(go_seen, 1'b0);
        rd(tic_pkg::TRANSCEIVE_CONTROL_IDX, v);
        check(v, 32'h083);
        rd(tic_pkg::IRQ_STATUS_IDX, v);
        check(v, 32'h20);
        kick(6'h01);
        check(rx_enable, 1'b1);
        for (int f = 0; f < 2; f++) begin
            radio_go = 1'b1;
            @(negedge clk);
            radio_go = 1'b0;
            wait_state(tic_pkg::TIC_RX_CLOSE);
            wait_state(tic_pkg::TIC_AWAITING_FRAME);
        end
        check({mem[0], mem[1], mem[2], mem[3]}, 32'hA53C8100);
        check({mem[4], mem[6], mem[7]}, 24'hA58100);
        kick(6'h10);
        check(fsm_state, tic_pkg::TIC_IDLE);
        $display("receive cases done");
        wr(tic_pkg::TRANSCEIVE_CONTROL_IDX, 32'h000);
        kick(6'h20);
        check(fsm_state, tic_pkg::TIC_PRE_LISTEN_WAIT);
        kick(6'h10);
        wr(tic_pkg::TRANSCEIVE_CONTROL_IDX, 32'h005);
        check(tx_single_byte, 1'b1);
        kick(6'h20);
        go_seen = 1'b0;
        kick(6'h0C);
        check({fsm_state, go_seen}, {tic_pkg::TIC_SENDING, 1'b1});
        kick(6'h02);
        check(tx_paused, 1'b1);
        go_seen = 1'b0;
        kick(6'h08);
        check({tx_paused, go_seen}, 2'b01);
        kick(6'h10);
        $display("transmit cases done");
        end_of_test();
    end
endmodule

/* verilog/tic_pkg.sv */
/*
 * Constants shared by the transceive and interrupt-flag control block.
 * Assumes register indices as delivered by the host serial command decoder.
 */
package tic_pkg;
    // Register indices on the internal register port.
    localparam logic [6:0] IRQ_ENABLE_IDX = 7'h01;
    localparam logic [6:0] IRQ_STATUS_IDX = 7'h02;
    localparam logic [6:0] INTERRUPT_FLAG_CLEAR_IDX = 7'h03;
    localparam logic [6:0] TRANSCEIVE_CONTROL_IDX = 7'h04;

    // Field positions of the transceive control register.
    localparam int TRIG_SEL_LSB = 4;
    localparam int TRIG_SEL_W = 6;
    localparam int SKIP_SEND_BIT = 3;
    localparam int BYTE_PER_FRAME_BIT = 2;
    localparam int AUTO_REARM_BIT = 1;
    localparam int INITIATOR_BIT = 0;
    localparam logic [9:0] CTRL_MASK = 10'h3FF;
    localparam logic [9:0] CTRL_RESET = 10'h000;

    // Interrupt flag layout.
    localparam int FLAG_W = 20;
    localparam int FSM_TRANSITION_FLAG_BIT = 5;
    localparam logic [19:0] FLAG_RESET = 20'h00000;
    localparam logic [19:0] ENABLE_FIXED_ONES = 20'hE0000;
    localparam logic [19:0] ENABLE_WRITE_MASK = 20'h1FFFF;

    // Transceive states, Gray coded along the usual path.
    typedef enum logic [2:0] {
        TIC_IDLE = 3'h0,
        TIC_PRE_SEND_WAIT = 3'h1,
        TIC_SENDING = 3'h3,
        TIC_PRE_LISTEN_WAIT = 3'h2,
        TIC_AWAITING_FRAME = 3'h6,
        TIC_RECEIVING = 3'h7,
        TIC_RX_CLOSE = 3'h5
    } tic_state_e;
endpackage

/* verilog/tic_transceive_irq_control.sv */
/*
 * Transceive control register, interrupt flag clear register, interrupt
 * flags with their enables, the transceive state machine and the receive
 * buffer writer.
 * Assumes the host serial command decoder presents one-cycle register
 * read and write strobes with a word index, and that the radio front end
 * presents its events as one-cycle pulses synchronous to clk.
 */
// What this block does
// - Clear bits 19..17 reset their flags.
// - Clear bits 16..14 reset their flags.
// - Clear bits 10..6 reset field flags.
// - Clear bits 5..0 reset transceive flags.
// - Six select bits enable state events.
// - Low select bits: idle, pre-send, sending.
// - High select bits: pre-listen, awaiting, receiving.
// - Skip-send suppresses the triggered transmission.
// - Entering pre-listen wait clears skip-send.
// - Byte-per-frame sends each byte framed.
// - Encoder pauses until next start trigger.
// - Auto-rearm re-enables receiver after frames.
// - Auto-rearm stores a status byte per frame.
// - Auto-rearm frames word aligned, padded with zero bytes.
// - Initiator bit selects polling-side operation.
// - Transceive starts sending or listening, loops.
// - State event reaches pin only when enabled.
module tic_transceive_irq_control #(
    parameter int BUF_ADDR_W = 9
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_idx,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic [19:0] flag_event,
    input wire logic cmd_transceive,
    input wire logic cmd_stop,
    input wire logic send_trigger,
    input wire logic guard_expired,
    input wire logic tx_byte_done,
    input wire logic tx_last_byte,
    input wire logic listen_wait_done,
    input wire logic rx_frame_start,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_frame_end,
    input wire logic [7:0] rx_frame_status,
    output logic irq,
    output logic [2:0] fsm_state,
    output logic tx_frame_go,
    output logic tx_paused,
    output logic tx_single_byte,
    output logic rx_enable,
    output logic buf_we,
    output logic [BUF_ADDR_W-1:0] buf_addr,
    output logic [7:0] buf_wdata
);
    initial begin
        if (BUF_ADDR_W < 2 || BUF_ADDR_W > 16) begin
            $error("BUF_ADDR_W must lie between 2 and 16");
        end
    end

    logic [9:0] ctrl_reg;
    logic [19:0] enable_reg;
    logic [19:0] flag_reg;
    tic_pkg::tic_state_e state_reg;
    tic_pkg::tic_state_e state_next;
    logic tx_paused_reg;
    logic [BUF_ADDR_W-1:0] ptr_reg;
    logic status_pending_reg;
    logic skip_clear;
    logic state_event;
    logic wr_ctrl;
    logic wr_enable;
    logic wr_clear;
    logic [19:0] clear_bits;

    // Maps a state onto its bit in the state-select field, or none.
    function automatic logic [5:0] state_select_bit(input tic_pkg::tic_state_e s);
        case (s)
            tic_pkg::TIC_IDLE: state_select_bit = 6'h01;
            tic_pkg::TIC_PRE_SEND_WAIT: state_select_bit = 6'h02;
            tic_pkg::TIC_SENDING: state_select_bit = 6'h04;
            tic_pkg::TIC_PRE_LISTEN_WAIT: state_select_bit = 6'h08;
            tic_pkg::TIC_AWAITING_FRAME: state_select_bit = 6'h10;
            tic_pkg::TIC_RECEIVING: state_select_bit = 6'h20;
            default: state_select_bit = 6'h00;
        endcase
    endfunction

    // Register write decode; clear bits act only in the write cycle.
    assign wr_ctrl = reg_wr && (reg_idx == tic_pkg::TRANSCEIVE_CONTROL_IDX);
    assign wr_enable = reg_wr && (reg_idx == tic_pkg::IRQ_ENABLE_IDX);
    assign wr_clear = reg_wr && (reg_idx == tic_pkg::INTERRUPT_FLAG_CLEAR_IDX);
    assign clear_bits = wr_clear ? reg_wdata[19:0] : 20'h00000;

    // Next state of the transceive cycle; stop always wins.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            tic_pkg::TIC_IDLE: begin
                if (cmd_transceive) begin
                    if (ctrl_reg[tic_pkg::INITIATOR_BIT]) begin
                        state_next = tic_pkg::TIC_PRE_SEND_WAIT;
                    end else begin
                        state_next = tic_pkg::TIC_PRE_LISTEN_WAIT;
                    end
                end
            end
            tic_pkg::TIC_PRE_SEND_WAIT: begin
                if (guard_expired && send_trigger) begin
                    if (ctrl_reg[tic_pkg::SKIP_SEND_BIT]) begin
                        state_next = tic_pkg::TIC_PRE_LISTEN_WAIT;
                    end else begin
                        state_next = tic_pkg::TIC_SENDING;
                    end
                end
            end
            tic_pkg::TIC_SENDING: begin
                if (tx_byte_done && tx_last_byte) begin
                    state_next = tic_pkg::TIC_PRE_LISTEN_WAIT;
                end
            end
            tic_pkg::TIC_PRE_LISTEN_WAIT: begin
                if (listen_wait_done) begin
                    state_next = tic_pkg::TIC_AWAITING_FRAME;
                end
            end
            tic_pkg::TIC_AWAITING_FRAME: begin
                if (rx_frame_start) begin
                    state_next = tic_pkg::TIC_RECEIVING;
                end
            end
            tic_pkg::TIC_RECEIVING: begin
                if (rx_frame_end) begin
                    if (ctrl_reg[tic_pkg::AUTO_REARM_BIT]) begin
                        state_next = tic_pkg::TIC_RX_CLOSE;
                    end else begin
                        state_next = tic_pkg::TIC_PRE_SEND_WAIT;
                    end
                end
            end
            tic_pkg::TIC_RX_CLOSE: begin
                if (!status_pending_reg && ptr_reg[1:0] == 2'h0) begin
                    state_next = tic_pkg::TIC_AWAITING_FRAME;
                end
            end
            default: state_next = tic_pkg::TIC_IDLE;
        endcase
        if (cmd_stop) begin
            state_next = tic_pkg::TIC_IDLE;
        end
    end

    // Entry into a selected state raises the transition event.
    assign state_event = (state_next != state_reg) &&
        |(state_select_bit(state_next) & ctrl_reg[tic_pkg::TRIG_SEL_LSB +: tic_pkg::TRIG_SEL_W]);
    assign skip_clear = (state_next == tic_pkg::TIC_PRE_LISTEN_WAIT) &&
        (state_reg != tic_pkg::TIC_PRE_LISTEN_WAIT);

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= tic_pkg::TIC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Transceive control register; hardware clears skip-send on entry.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= tic_pkg::CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= reg_wdata[9:0] & tic_pkg::CTRL_MASK;
            end
            if (skip_clear) begin
                ctrl_reg[tic_pkg::SKIP_SEND_BIT] <= 1'b0;
            end
        end
    end

    // Interrupt enable register; the three error enables are fixed on.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enable_reg <= tic_pkg::FLAG_RESET;
        end else if (wr_enable) begin
            enable_reg <= reg_wdata[19:0] & tic_pkg::ENABLE_WRITE_MASK;
        end
    end

    // Sticky flags: a one clears its flag, a new event beats the clear.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flag_reg <= tic_pkg::FLAG_RESET;
        end else begin
            flag_reg <= (flag_reg & ~clear_bits) | flag_event;
            if (state_event) begin
                flag_reg[tic_pkg::FSM_TRANSITION_FLAG_BIT] <= 1'b1;
            end
        end
    end

    // Interrupt pin: a flag reaches it only through its enable.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flag_reg & (enable_reg | tic_pkg::ENABLE_FIXED_ONES));
        end
    end

    // Register read data; the clear register reads as zero.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_idx)
                tic_pkg::IRQ_ENABLE_IDX: reg_rdata <= {12'h000, enable_reg | tic_pkg::ENABLE_FIXED_ONES};
                tic_pkg::IRQ_STATUS_IDX: reg_rdata <= {12'h000, flag_reg};
                tic_pkg::TRANSCEIVE_CONTROL_IDX: reg_rdata <= {22'h000000, ctrl_reg};
                default: reg_rdata <= 32'h00000000;
            endcase
        end
    end

    // Byte-per-frame pause: after each byte the encoder waits for a trigger.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_paused_reg <= 1'b0;
        end else if (state_next != tic_pkg::TIC_SENDING) begin
            tx_paused_reg <= 1'b0;
        end else if (tx_paused_reg && send_trigger) begin
            tx_paused_reg <= 1'b0;
        end else if (tx_byte_done && ctrl_reg[tic_pkg::BYTE_PER_FRAME_BIT]) begin
            tx_paused_reg <= 1'b1;
        end
    end

    // Encoder controls: a frame starts on entry or on resume after a pause.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_frame_go <= 1'b0;
            tx_single_byte <= 1'b0;
            rx_enable <= 1'b0;
            fsm_state <= 3'h0;
        end else begin
            tx_frame_go <= (state_next == tic_pkg::TIC_SENDING) &&
                ((state_reg != tic_pkg::TIC_SENDING) || (tx_paused_reg && send_trigger));
            tx_single_byte <= ctrl_reg[tic_pkg::BYTE_PER_FRAME_BIT];
            rx_enable <= (state_next == tic_pkg::TIC_AWAITING_FRAME) ||
                (state_next == tic_pkg::TIC_RECEIVING);
            fsm_state <= state_next;
        end
    end
    assign tx_paused = tx_paused_reg;

    // Status byte owed at the end of each frame in auto-rearm operation.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_pending_reg <= 1'b0;
        end else if (state_reg == tic_pkg::TIC_RECEIVING && state_next == tic_pkg::TIC_RX_CLOSE) begin
            status_pending_reg <= 1'b1;
        end else if (state_reg == tic_pkg::TIC_RX_CLOSE || state_next == tic_pkg::TIC_IDLE) begin
            status_pending_reg <= 1'b0;
        end
    end

    // Buffer writer: data bytes, then status byte, then zero padding.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ptr_reg <= '0;
            buf_we <= 1'b0;
            buf_addr <= '0;
            buf_wdata <= 8'h00;
        end else begin
            buf_we <= 1'b0;
            if (state_reg == tic_pkg::TIC_IDLE && cmd_transceive) begin
                ptr_reg <= '0;
            end else if (state_reg == tic_pkg::TIC_RECEIVING && rx_byte_valid) begin
                buf_we <= 1'b1;
                buf_addr <= ptr_reg;
                buf_wdata <= rx_byte;
                ptr_reg <= ptr_reg + 1'b1;
            end else if (state_reg == tic_pkg::TIC_RX_CLOSE && status_pending_reg) begin
                buf_we <= 1'b1;
                buf_addr <= ptr_reg;
                buf_wdata <= rx_frame_status;
                ptr_reg <= ptr_reg + 1'b1;
            end else if (state_reg == tic_pkg::TIC_RX_CLOSE && ptr_reg[1:0] != 2'h0) begin
                buf_we <= 1'b1;
                buf_addr <= ptr_reg;
                buf_wdata <= 8'h00;
                ptr_reg <= ptr_reg + 1'b1;
            end
        end
    end
endmodule
